// *** core/sfs_defs.vh ***
// Constants for the safety fault supervisor: register map, fields, codes and timing.
// Assumes a single 250 MHz system clock; included by the supervisor core.
`ifndef SFS_DEFS_VH
`define SFS_DEFS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SFS_REG_CTRL        8'h00
`define SFS_REG_STATUS      8'h04
`define SFS_REG_CODE        8'h08
`define SFS_REG_KICK        8'h0C
`define SFS_REG_CALCHK      8'h10
`define SFS_REG_GAIN        8'h14
`define SFS_REG_ZERO        8'h18
`define SFS_REG_ID          8'h1C

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SFS_CTRL_OUT_ON     0
`define SFS_CTRL_HV_STATE   1
`define SFS_CTRL_EXT_SEL    2
`define SFS_CTRL_SER_ERR    3
`define SFS_CTRL_DIV_ERR    4
`define SFS_CTRL_CAL_ERR    5
`define SFS_CTRL_FORCE_TRIP 6
`define SFS_CTRL_SAFE_RST   7
`define SFS_CTRL_WIDTH      8
`define SFS_CTRL_RESET      8'h00

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define SFS_ST_TRIP         0
`define SFS_ST_TRIP_DLY     1
`define SFS_ST_OUT_ON       2
`define SFS_ST_PANEL_LOCK   3
`define SFS_ST_EXT_ERR      4
`define SFS_ST_HV_EN        5
`define SFS_ST_LATCH_EN     6
`define SFS_ST_CODE_LSB     8

// ----------------------------------------
// Calibration check fields
// ----------------------------------------
`define SFS_CAL_GAIN_BAD    0
`define SFS_CAL_ZERO_BAD    1
`define SFS_GAIN_UNITY      16'h8000
`define SFS_ZERO_NULL       16'h0000

// ----------------------------------------
// Failure codes
// ----------------------------------------
`define SFS_CODE_NONE       4'h0
`define SFS_CODE_TEMP       4'h1
`define SFS_CODE_HV         4'h2
`define SFS_CODE_SERIAL     4'h3
`define SFS_CODE_DIVIDER    4'h4
`define SFS_CODE_SAFETY     4'h5
`define SFS_CODE_CALMEM     4'h6
`define SFS_CODE_HVSUP      4'h7
`define SFS_CODE_AMPSUP     4'h8
`define SFS_CODE_LOGSUP     4'h9

// ----------------------------------------
// Timing
// ----------------------------------------
`define SFS_CLK_HZ          250000000
`define SFS_WD_MS           18
`define SFS_DELAY_MS        47
`define SFS_TEMP_S          60
`define SFS_LOGSUP_US       100

`endif

// *** core/sfs_supervisor.v ***
// Safety fault supervisor: fault code mapping, safety watchdog, trip outputs.
// Assumes fault inputs arrive asynchronously from analog detectors and that
// the control CPU drives the register port synchronously on clk_sys.
//
// How it works
// - Over-temperature reports code 1
// - After one minute: output off, code cleared
// - HV status outside HV state gives code 2
// - Codes 2-4: output off, then 5 after a trip with fault cleared
// - Serial transfer error reports code 3
// - Divider latch error reports code 4
// - 18 ms retriggerable timer raises trip
// - Delayed trip follows trip by 47 ms
// - Trip removes 1 kV drive, 400 V supply
// - Trip visible as status bit to CPU
// - Delayed trip disconnects power and sense paths
// - Delayed trip disables serial converter registers
// - Delayed trip tristates control latch outputs
// - Calibration memory fault reports code 6
// - HV supply failure reports code 7
// - Amplifier supply failure reports code 8
// - Logic supply failure: code 9, then 8
// - Logic supply failure disables 400 V supply
// - External lock without reference raises error
// - Code 5 locks panel until safety reset
// - Failing cal constant: unity gain, zero offset
`timescale 1ns/1ps
`include "sfs_defs.vh"

module sfs_supervisor #(
   parameter WD_CYCLES    = (`SFS_CLK_HZ / 1000) * `SFS_WD_MS,
   parameter DELAY_CYCLES = (`SFS_CLK_HZ / 1000) * `SFS_DELAY_MS,
   parameter TEMP_CYCLES  = 64'd1 * `SFS_CLK_HZ * `SFS_TEMP_S,
   parameter LOG_CYCLES   = (`SFS_CLK_HZ / 1000000) * `SFS_LOGSUP_US,
   parameter LATCH_W      = 16,
   // Identity word: the value is arbitrary and names no part
   parameter [31:0] ID_VALUE = 32'h5AFE_0001
) (
   input  wire               clk_sys,
   input  wire               reset_n,
   input  wire [7:0]         addr,
   input  wire [31:0]        wdata,
   input  wire               wr_stb,
   input  wire               rd_stb,
   output reg  [31:0]        rdata,
   input  wire               gated_write_strobe,
   input  wire               over_temperature_flag,
   input  wire               high_voltage_status,
   input  wire               hv_supply_fail,
   input  wire               amp_supply_fail,
   input  wire               logic_supply_fail,
   input  wire               ext_reference_present,
   input  wire [LATCH_W-1:0] latch_data,
   output reg                watchdog_trip,
   output reg                watchdog_trip_delayed,
   output wire               hv_drive_en,
   output wire               hv_supply_en,
   output wire               output_relay_on,
   output wire               converter_reg_en,
   output wire [LATCH_W-1:0] latch_out,
   output wire [LATCH_W-1:0] latch_oe,
   output reg  [3:0]         fail_code,
   output reg                ext_freq_error,
   output wire               panel_inhibit
);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Agreement filter: a level counts once stages two and three agree; otherwise the last level holds.
   localparam NSYNC = 7;
   wire [NSYNC-1:0] raw_in = {gated_write_strobe, ext_reference_present, logic_supply_fail,
                              amp_supply_fail, hv_supply_fail, high_voltage_status,
                              over_temperature_flag};
   reg  [NSYNC-1:0] sync1;
   reg  [NSYNC-1:0] sync2;
   reg  [NSYNC-1:0] sync3;
   reg  [NSYNC-1:0] filt;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= {NSYNC{1'b0}};
         sync2 <= {NSYNC{1'b0}};
         sync3 <= {NSYNC{1'b0}};
         filt  <= {NSYNC{1'b0}};
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
         sync3 <= sync2;
         filt  <= (sync2 & sync3) | (filt & (sync2 | sync3));
      end
   end

   wire s_temp   = filt[0];
   wire s_hv     = filt[1];
   wire s_hvsup  = filt[2];
   wire s_ampsup = filt[3];
   wire s_logsup = filt[4];
   wire s_extref = filt[5];
   wire s_strobe = filt[6];
   reg  strobe_d;

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   reg  [`SFS_CTRL_WIDTH-1:0] ctrl;
   reg  [1:0]                 cal_bad;
   reg  [15:0]                gain_raw;
   reg  [15:0]                zero_raw;
   // Output-off request from the code sequencer; it beats a CPU write
   // of the output bit in the same cycle, so the output stays off while codes 2-4 are held.
   reg                        force_off;
   wire                       wr_ctrl = wr_stb && (addr == `SFS_REG_CTRL);
   wire                       safe_rst = wr_ctrl && wdata[`SFS_CTRL_SAFE_RST];
   wire                       kick = wr_stb && (addr == `SFS_REG_KICK);

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl     <= `SFS_CTRL_RESET;
         cal_bad  <= 2'b00;
         gain_raw <= `SFS_GAIN_UNITY;
         zero_raw <= `SFS_ZERO_NULL;
      end else begin
         if (wr_ctrl)
            ctrl <= wdata[`SFS_CTRL_WIDTH-1:0] & ~(8'h01 << `SFS_CTRL_SAFE_RST);
         if (wr_stb && (addr == `SFS_REG_CALCHK))
            cal_bad <= wdata[1:0];
         if (wr_stb && (addr == `SFS_REG_GAIN))
            gain_raw <= wdata[15:0];
         if (wr_stb && (addr == `SFS_REG_ZERO))
            zero_raw <= wdata[15:0];
         if (force_off)
            ctrl[`SFS_CTRL_OUT_ON] <= 1'b0;
         if (ctrl[`SFS_CTRL_FORCE_TRIP] && watchdog_trip)
            ctrl[`SFS_CTRL_FORCE_TRIP] <= 1'b0;
      end
   end

   // ----------------------------------------
   // Safety watchdog
   // ----------------------------------------
   reg  [31:0] wd_cnt;
   reg  [31:0] dly_cnt;
   wire        retrig = (s_strobe && !strobe_d) || kick;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         strobe_d              <= 1'b0;
         wd_cnt                <= 32'h0000_0000;
         dly_cnt               <= 32'h0000_0000;
         watchdog_trip         <= 1'b0;
         watchdog_trip_delayed <= 1'b0;
      end else begin
         strobe_d <= s_strobe;
         if (watchdog_trip) begin
            if (safe_rst) begin
               watchdog_trip         <= 1'b0;
               watchdog_trip_delayed <= 1'b0;
               wd_cnt                <= 32'h0000_0000;
               dly_cnt               <= 32'h0000_0000;
            end else if (dly_cnt >= DELAY_CYCLES - 1) begin
               watchdog_trip_delayed <= 1'b1;
            end else begin
               dly_cnt <= dly_cnt + 32'h0000_0001;
            end
         end else if (ctrl[`SFS_CTRL_FORCE_TRIP] || wd_cnt >= WD_CYCLES - 1) begin
            watchdog_trip <= 1'b1;
         end else if (retrig) begin
            wd_cnt <= 32'h0000_0000;
         end else begin
            wd_cnt <= wd_cnt + 32'h0000_0001;
         end
      end
   end

   // ----------------------------------------
   // Fault code sequencer
   // ----------------------------------------
   localparam ST_IDLE  = 3'd0;
   localparam ST_TEMP  = 3'd1;
   localparam ST_GRAVE = 3'd2;
   localparam ST_SAFE  = 3'd3;
   localparam ST_LOG   = 3'd4;
   localparam ST_COOL  = 3'd5;

   reg  [2:0]  state;
   reg  [63:0] tmr;
   reg  [3:0]  grave_code;

   // Grave faults outrank supply and memory faults, which outrank temperature.
   always @* begin
      grave_code = `SFS_CODE_NONE;
      if (s_hv && !ctrl[`SFS_CTRL_HV_STATE])
         grave_code = `SFS_CODE_HV;
      else if (ctrl[`SFS_CTRL_SER_ERR])
         grave_code = `SFS_CODE_SERIAL;
      else if (ctrl[`SFS_CTRL_DIV_ERR])
         grave_code = `SFS_CODE_DIVIDER;
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state     <= ST_IDLE;
         tmr       <= 64'h0000_0000_0000_0000;
         force_off <= 1'b0;
         fail_code <= `SFS_CODE_NONE;
      end else begin
         force_off <= 1'b0;
         case (state)
            ST_IDLE: begin
               tmr <= 64'h0000_0000_0000_0000;
               if (grave_code != `SFS_CODE_NONE) begin
                  fail_code <= grave_code;
                  force_off <= 1'b1;
                  state     <= ST_GRAVE;
               end else if (s_logsup) begin
                  fail_code <= `SFS_CODE_LOGSUP;
                  state     <= ST_LOG;
               end else if (s_ampsup) begin
                  fail_code <= `SFS_CODE_AMPSUP;
               end else if (s_hvsup) begin
                  fail_code <= `SFS_CODE_HVSUP;
               end else if (ctrl[`SFS_CTRL_CAL_ERR] || cal_bad != 2'b00) begin
                  fail_code <= `SFS_CODE_CALMEM;
               end else if (s_temp) begin
                  fail_code <= `SFS_CODE_TEMP;
                  state     <= ST_TEMP;
               end else begin
                  fail_code <= `SFS_CODE_NONE;
               end
            end
            ST_TEMP: begin
               if (tmr >= TEMP_CYCLES - 1) begin
                  force_off <= 1'b1;
                  fail_code <= `SFS_CODE_NONE;
                  state     <= ST_COOL;
               end else begin
                  tmr <= tmr + 64'h0000_0000_0000_0001;
               end
            end
            // Code 1 stays cleared until the heat is gone or the CPU asks for
            // output again; going straight to idle would re-raise it next cycle.
            ST_COOL: begin
               if (!s_temp || (wr_ctrl && wdata[`SFS_CTRL_OUT_ON]))
                  state <= ST_IDLE;
            end
            ST_GRAVE: begin
               force_off <= 1'b1;
               if (watchdog_trip && grave_code == `SFS_CODE_NONE) begin
                  fail_code <= `SFS_CODE_SAFETY;
                  state     <= ST_SAFE;
               end
            end
            ST_SAFE: begin
               if (safe_rst) begin
                  fail_code <= `SFS_CODE_NONE;
                  state     <= ST_IDLE;
               end
            end
            // Code 9 is only a flash: code 8 then holds while the supply is down,
            // so the display does not cycle between the two.
            ST_LOG: begin
               if (tmr >= LOG_CYCLES - 1) begin
                  fail_code <= `SFS_CODE_AMPSUP;
                  if (!s_logsup)
                     state <= ST_IDLE;
               end else begin
                  tmr <= tmr + 64'h0000_0000_0000_0001;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // Protective outputs
   // ----------------------------------------
   reg  [LATCH_W-1:0] latch_q;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latch_q        <= {LATCH_W{1'b0}};
         ext_freq_error <= 1'b0;
      end else begin
         if (!watchdog_trip_delayed)
            latch_q <= latch_data;
         ext_freq_error <= ctrl[`SFS_CTRL_EXT_SEL] && !s_extref;
      end
   end

   assign hv_drive_en      = !watchdog_trip;
   assign hv_supply_en     = !watchdog_trip && !s_logsup;
   assign output_relay_on  = ctrl[`SFS_CTRL_OUT_ON] && !watchdog_trip_delayed;
   assign converter_reg_en = !watchdog_trip_delayed;
   assign latch_out        = latch_q;
   assign latch_oe         = {LATCH_W{!watchdog_trip_delayed}};
   assign panel_inhibit    = (state == ST_SAFE) || (state == ST_GRAVE);

   // Failing constants are replaced, output left on.
   wire [15:0] gain_eff = cal_bad[`SFS_CAL_GAIN_BAD] ? `SFS_GAIN_UNITY : gain_raw;
   wire [15:0] zero_eff = cal_bad[`SFS_CAL_ZERO_BAD] ? `SFS_ZERO_NULL : zero_raw;

   // ----------------------------------------
   // Read data
   // ----------------------------------------
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= 32'h0000_0000;
      end else if (rd_stb) begin
         case (addr)
            `SFS_REG_CTRL:   rdata <= {24'h00_0000, ctrl};
            `SFS_REG_STATUS: rdata <= {20'h0_0000, fail_code, 1'b0, !watchdog_trip_delayed,
                                       hv_supply_en, ext_freq_error, panel_inhibit,
                                       output_relay_on, watchdog_trip_delayed,
                                       watchdog_trip};
            `SFS_REG_CODE:   rdata <= {28'h000_0000, fail_code};
            `SFS_REG_CALCHK: rdata <= {30'h0000_0000, cal_bad};
            `SFS_REG_GAIN:   rdata <= {16'h0000, gain_eff};
            `SFS_REG_ZERO:   rdata <= {16'h0000, zero_eff};
            `SFS_REG_ID:     rdata <= ID_VALUE;  // Arbitrary value
            default:         rdata <= 32'h0000_0000;
         endcase
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

endmodule

// *** bench/sfs_supervisor_props.sv ***
// Checker for the safety fault supervisor, bound to its top module.
// Assumes the shortened counts of the bench: trip delay 300, code 9 hold 20, heat hold 500.
`timescale 1ns/1ps
module sfs_supervisor_props #(
   parameter DELAY_CYCLES = 300,
   parameter LATCH_W      = 16
) (
   input wire logic               clk_sys,
   input wire logic               reset_n,
   input wire logic [7:0]         addr,
   input wire logic [31:0]        wdata,
   input wire logic               wr_stb,
   input wire logic               rd_stb,
   input wire logic [31:0]        rdata,
   input wire logic               logic_supply_fail,
   input wire logic               ext_reference_present,
   input wire logic               watchdog_trip,
   input wire logic               watchdog_trip_delayed,
   input wire logic               hv_drive_en,
   input wire logic               hv_supply_en,
   input wire logic               output_relay_on,
   input wire logic               converter_reg_en,
   input wire logic [LATCH_W-1:0] latch_oe,
   input wire logic [3:0]         fail_code,
   input wire logic               ext_freq_error,
   input wire logic               panel_inhibit
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   int unsigned gap;
   // Cycles since the trip rose; the delayed trip is timed against it
   always_ff @(posedge clk_sys or negedge reset_n)
      if (!reset_n || !watchdog_trip) gap <= 0;
      else gap <= gap + 1;
   sequence s_safe_rst;
      $past(wr_stb) && $past(addr) == 8'h00 && $past(wdata[7]);
   endsequence
   sequence s_left9;
      ##[0:25] fail_code != 4'h9;
   endsequence
   chk_trip_hv_off: assert property (
      watchdog_trip |-> !hv_drive_en && !hv_supply_en) else $error("trip left hv on");
   chk_delay_gap: assert property (
      $rose(watchdog_trip_delayed) |-> gap >= DELAY_CYCLES - 3 && gap <= DELAY_CYCLES + 2)
      else $error("delayed trip mistimed");
   chk_delay_order: assert property (
      watchdog_trip_delayed |-> watchdog_trip) else $error("delayed trip alone");
   chk_lock_safe: assert property (
      watchdog_trip_delayed |-> !converter_reg_en && latch_oe == '0 && !output_relay_on)
      else $error("delayed trip left outputs live");
   chk_trip_release: assert property (
      $fell(watchdog_trip) |-> s_safe_rst) else $error("trip cleared without safety reset");
   chk_code5_panel: assert property (
      fail_code == 4'h5 |-> panel_inhibit) else $error("panel free in code 5");
   chk_logsup_hv: assert property (
      logic_supply_fail [*6] |-> !hv_supply_en) else $error("hv supply on at logic fail");
   chk_code9_left: assert property (
      fail_code == 4'h9 |-> s_left9) else $error("code 9 held too long");
   chk_heat_limit: assert property (
      fail_code == 4'h1 |-> ##[0:505] fail_code != 4'h1) else $error("code 1 not cleared");
   chk_ref_ok: assert property (
      ext_reference_present [*7] |-> !ext_freq_error) else $error("ext error with reference");
   chk_rdata_idle: assert property (
      !$past(rd_stb) |-> rdata == 32'h0000_0000) else $error("rdata not idle");
endmodule
bind sfs_supervisor sfs_supervisor_props #(.DELAY_CYCLES(DELAY_CYCLES), .LATCH_W(LATCH_W))
   u_props (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata),
   .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .logic_supply_fail(logic_supply_fail),
   .ext_reference_present(ext_reference_present), .watchdog_trip(watchdog_trip),
   .watchdog_trip_delayed(watchdog_trip_delayed), .hv_drive_en(hv_drive_en),
   .hv_supply_en(hv_supply_en), .output_relay_on(output_relay_on),
   .converter_reg_en(converter_reg_en), .latch_oe(latch_oe), .fail_code(fail_code),
   .ext_freq_error(ext_freq_error), .panel_inhibit(panel_inhibit));

// *** bench/sfs_cpu_model.sv ***
// Control CPU stand-in: pulses the watchdog retrigger pin, shuts down on a trip.
// Assumes the supervisor synchronises the pin to clk_sys.
`timescale 1ns/1ps
module sfs_cpu_model #(
   parameter int PERIOD = 40
) (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic kick_en,
   input  wire logic watchdog_trip,
   output logic      gated_write_strobe,
   output logic      shutdown_seen
);
   int cnt;
   // Two-cycle pulse so the pin filter cannot swallow it
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         gated_write_strobe <= 1'b0;
         shutdown_seen <= 1'b0;
      end else begin
         cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
         shutdown_seen <= watchdog_trip;
         gated_write_strobe <= kick_en && !watchdog_trip && cnt < 2;
      end
   end
endmodule

// *** bench/sfs_supervisor_tb.sv ***
// Self-checking bench for the safety fault supervisor with shortened counts.
// Assumes the CPU stand-in and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "sfs_defs.vh"
module sfs_supervisor_tb;
   logic        clk_sys = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic        wr_stb = 1'b0, rd_stb = 1'b0, kick_en = 1'b1;
   logic        high_voltage_status = 1'b0, over_temperature_flag = 1'b0;
   logic        hv_supply_fail = 1'b0, amp_supply_fail = 1'b0, logic_supply_fail = 1'b0;
   logic        ext_reference_present = 1'b1;
   logic [31:0] lfsr = 32'h0000_ccbe;
   logic [7:0]  ctrl = 8'h00;
   logic [31:0] rdata;
   logic [15:0] latch_out, latch_oe, lat_prev;
   logic [3:0]  fail_code;
   logic        gated_write_strobe, watchdog_trip, watchdog_trip_delayed, hv_drive_en;
   logic        hv_supply_en, output_relay_on, converter_reg_en, ext_freq_error;
   logic        panel_inhibit, shutdown_seen;
   int          errors = 0;
   int          total_checks = 0;
   logic [31:0] exp_q[$];
   always #2 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Latch data seen one edge ago is what the latches should show
   always @(posedge clk_sys) begin
      lfsr <= lfsr_next(lfsr);
      lat_prev <= lfsr[15:0];
   end
   sfs_supervisor #(.WD_CYCLES(200), .DELAY_CYCLES(300), .TEMP_CYCLES(500), .LOG_CYCLES(20))
   uut (.clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .gated_write_strobe(gated_write_strobe),
      .over_temperature_flag(over_temperature_flag), .high_voltage_status(high_voltage_status),
      .hv_supply_fail(hv_supply_fail), .amp_supply_fail(amp_supply_fail),
      .logic_supply_fail(logic_supply_fail), .ext_reference_present(ext_reference_present),
      .latch_data(lfsr[15:0]), .watchdog_trip(watchdog_trip),
      .watchdog_trip_delayed(watchdog_trip_delayed), .hv_drive_en(hv_drive_en),
      .hv_supply_en(hv_supply_en), .output_relay_on(output_relay_on),
      .converter_reg_en(converter_reg_en), .latch_out(latch_out), .latch_oe(latch_oe),
      .fail_code(fail_code), .ext_freq_error(ext_freq_error), .panel_inhibit(panel_inhibit));
   sfs_cpu_model cpu (.clk_sys(clk_sys), .reset_n(reset_n), .kick_en(kick_en),
      .watchdog_trip(watchdog_trip), .gated_write_strobe(gated_write_strobe),
      .shutdown_seen(shutdown_seen));
   // ----------------------------------------
   // Model and bus tasks
   // ----------------------------------------
   // Fault order: hv, serial, divider, logic, amp, hv supply, cal, heat
   function automatic logic [3:0] model_code(input logic [7:0] f);
      int codes[8] = '{2, 3, 4, 9, 8, 7, 6, 1};
      for (int i = 0; i < 8; i++)
         if (f[7-i]) return 4'(codes[i]);
      return 4'h0;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk_sys);
      wr_stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      @(posedge clk_sys);
      addr <= a;
      rd_stb <= 1'b1;
      exp_q.push_back(exp & m);
      @(posedge clk_sys);
      rd_stb <= 1'b0;
      #1 chk("rdata", exp_q.pop_front(), rdata & m);
   endtask
   task automatic set_fault(input int i, input logic v);
      @(posedge clk_sys);
      case (i)
         0: high_voltage_status <= v;
         1: ctrl[3] = v;
         2: ctrl[4] = v;
         3: logic_supply_fail <= v;
         4: amp_supply_fail <= v;
         5: hv_supply_fail <= v;
         6: ctrl[5] = v;
         7: over_temperature_flag <= v;
         default: ext_reference_present <= !v;
      endcase
      wr(`SFS_REG_CTRL, {24'h0, ctrl});
   endtask
   task automatic report_and_stop();
      if (errors == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd(`SFS_REG_STATUS, 32'h0000_0060, 32'hffff_ffff);
      wr(8'h20, lfsr);
      rd(8'h20, 32'h0000_0000, 32'hffff_ffff);
      ctrl = 8'h03;
      set_fault(0, 1'b1);
      cyc(10);
      chk("code", 4'h0, fail_code);
      chk("latch", lat_prev, latch_out);
      ctrl[1] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         ctrl[0] = 1'b1;
         set_fault(i, 1'b1);
         cyc(10);
         chk("code", model_code(8'h80 >> i), fail_code);
         if (i < 3) begin
            chk("relay", 1'b0, output_relay_on);
            wr(`SFS_REG_CTRL, {24'h0, ctrl | 8'h40});
            cyc(10);
            chk("trip", 1'b1, watchdog_trip);
            chk("shutdown", 1'b1, shutdown_seen);
            ctrl[0] = 1'b0;
            set_fault(i, 1'b0);
            cyc(10);
            chk("code", 4'h5, fail_code);
            chk("panel", 1'b1, panel_inhibit);
            wr(`SFS_REG_CTRL, {24'h0, ctrl | 8'h80});
            cyc(10);
            chk("code", 4'h0, fail_code);
            chk("relay", 1'b0, output_relay_on);
         end else begin
            if (i == 3) begin
               cyc(30);
               chk("code", 4'h8, fail_code);
               chk("hv_en", 1'b0, hv_supply_en);
            end
            if (i == 7) begin
               cyc(500);
               chk("code", 4'h0, fail_code);
               chk("relay", 1'b0, output_relay_on);
            end
            ctrl[0] = 1'b0;
            set_fault(i, 1'b0);
            cyc(10);
            chk("code", 4'h0, fail_code);
         end
      end
      // Retrigger by register only, then let the timer run out
      @(posedge clk_sys);
      kick_en <= 1'b0;
      repeat (3) begin
         cyc(150);
         wr(`SFS_REG_KICK, lfsr);
      end
      cyc(185);
      chk("trip", 1'b0, watchdog_trip);
      cyc(30);
      chk("trip", 1'b1, watchdog_trip);
      chk("drive", 1'b0, hv_drive_en);
      rd(`SFS_REG_STATUS, 32'h0000_0001, 32'h0000_0021);
      cyc(250);
      chk("delayed", 1'b0, watchdog_trip_delayed);
      cyc(60);
      chk("delayed", 1'b1, watchdog_trip_delayed);
      chk("convert", 1'b0, converter_reg_en);
      chk("latch_oe", 16'h0000, latch_oe);
      chk("relay", 1'b0, output_relay_on);
      wr(`SFS_REG_CTRL, {24'h0, ctrl | 8'h80});
      kick_en <= 1'b1;
      cyc(10);
      chk("trip", 1'b0, watchdog_trip);
      chk("latch_oe", 16'hffff, latch_oe);
      ctrl[2] = 1'b1;
      set_fault(8, 1'b1);
      cyc(10);
      chk("ef", 1'b1, ext_freq_error);
      ctrl[2] = 1'b0;
      set_fault(8, 1'b1);
      cyc(10);
      chk("ef", 1'b0, ext_freq_error);
      ctrl = 8'h01;
      set_fault(8, 1'b0);
      // Odd values differ from both defaults, so a missed substitution shows
      wr(`SFS_REG_GAIN, lfsr | 32'h0000_0001);
      wr(`SFS_REG_ZERO, lfsr | 32'h0000_0001);
      wr(`SFS_REG_CALCHK, 32'h0000_0003);
      rd(`SFS_REG_GAIN, 32'(`SFS_GAIN_UNITY), 32'h0000_ffff);
      rd(`SFS_REG_ZERO, 32'h0000_0000, 32'h0000_ffff);
      chk("relay", 1'b1, output_relay_on);
      rd(`SFS_REG_CODE, 32'h0000_0006, 32'hffff_ffff);
      rd(`SFS_REG_CTRL, 32'h0000_0001, 32'hffff_ffff);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      cyc(3);
      reset_n <= 1'b1;
      rd(`SFS_REG_STATUS, 32'h0000_0060, 32'hffff_ffff);
      report_and_stop();
   end
endmodule
